// *** eprom_port_defs.svh ***
// Named constants for the EPROM program/verify port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EPROM_PORT_DEFS_SVH
`define EPROM_PORT_DEFS_SVH

// Address as seen on the programming pins: low byte port 1, high bits port 2
`define ADDR_BITS 14
`define ADDR_LO_BITS 8
`define ADDR_HI_BITS 6

// Strobe pulses needed per byte
`define PULSES_ARRAY 5'h05
`define PULSES_CONFIG 5'h19
`define PULSE_CNT_BITS 5

// Erased EPROM byte
`define ERASED_BYTE 8'hff

// Startup option byte fields
`define OPT_WDT_POR_BIT 3

// Identification byte addresses
`define SIG_ADDR_MAKER 14'h0030
`define SIG_ADDR_MODEL 14'h0031
`define SIG_ADDR_EXTENSION 14'h0060

// Power-on reset delay in oscillator clocks
`define POR_CLOCKS 65536
`define POR_CNT_BITS 17

// Cycles the external-access synchroniser needs after reset release
`define EA_SETTLE 2'h3

`endif

// *** eprom_port_pkg.sv ***
// Types shared by the EPROM program/verify port modules.
// Assumes eprom_port_defs.svh is on the include path.
`include "eprom_port_defs.svh"

package eprom_port_pkg;

    // Operation chosen by the programmer through the control pins
    typedef enum logic [2:0] {
        OP_VERIFY = 3'h0,
        OP_PGM_ARRAY = 3'h1,
        OP_PGM_ENCRYPT = 3'h2,
        OP_PGM_LOCK = 3'h3,
        OP_PGM_OPTION = 3'h4,
        OP_READ_OPTION = 3'h5,
        OP_READ_SIGNATURE = 3'h6,
        OP_NONE = 3'h7
    } op_select_t;

    // Strobe pulse tracker, Gray along idle -> low -> counted
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOW = 2'h1,
        ST_COUNTED = 2'h3
    } strobe_state_t;

    // Programming pins as one group
    typedef struct packed {
        logic [`ADDR_BITS-1:0] addr;
        logic [7:0] data;
        op_select_t op;
        logic program_strobe_n;
        logic vpp_high;
        logic program_strobe_enable_n;
    } program_strobe_pins_t;

endpackage : eprom_port_pkg

// *** power_on_reset_counter.sv ***
// Power-on reset delay: counts oscillator clocks once the oscillator is valid.
// Assumes clk is the oscillator and rst_n is already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_port_defs.svh"

module power_on_reset_counter #(
    parameter int POR_CYCLES = `POR_CLOCKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Oscillator level detector, asynchronous
    input wire logic oscillator_input_valid,
    // Release
    output logic por_done
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic [`POR_CNT_BITS-1:0] count;
        logic done;
    } por_state_t;

    por_state_t st;
    por_state_t next_st;

    localparam logic [`POR_CNT_BITS-1:0] LAST = `POR_CNT_BITS'(POR_CYCLES - 1);

    always_comb begin
        next_st = st;
        next_st.meta = oscillator_input_valid;
        next_st.sync = st.meta;
        // Counting starts only once the oscillator is seen valid
        if (st.sync && !st.done) begin // R16
            if (st.count == LAST) begin
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count + `POR_CNT_BITS'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign por_done = st.done;

endmodule : power_on_reset_counter
`default_nettype wire

// *** eprom_program_verify_port.sv ***
// EPROM program/verify port with encryption array, option byte, signature,
// lock, external-access latch and power-on reset delay.
// Assumes a programmer fixture drives the pins; all pins are asynchronous.
//
// Summary of operation
// R01: Programmer places address on ports 1 and 2, data on port 0.
// R02: Programmer applies address, then data, selects operation, raises supply, then strobes.
// R03: Five strobes per array byte, 25 per encryption, lock or option byte.
// R04: Programmer clocks the device between 4 and 6 MHz while programming.
// R05: Verify returns memory byte XNOR encryption byte.
// R06: All-ones encryption bytes give true data; anything else scrambles.
// R07: Encryption array contents are never readable.
// R08: No verify mode bypasses the encryption combination.
// R09: Option bit 3 one disables watchdog reset at power-up, zero enables.
// R10: Programmer writes ones into unused option bits 7..4 and 2..0.
// R11: Configuration lives in nonvolatile option bits, valid before execution. Here the option flops are reset to all ones on every reset.
// R12: Identification bytes for maker, model, extension at three fixed addresses.
// R13: Locked: external code-table reads of internal memory are blocked.
// R14: Locked: external-access pin sampled at reset and held until next reset.
// R15: Lock state has no readable view, only its effect.
// R16: Reset releases after 65,536 clocks counted from a valid oscillator.
// R17: Programmer holds address, data and operation stable across a byte's strobes.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_port_defs.svh"

module eprom_program_verify_port #(
    parameter int MEM_DEPTH = 16384,
    parameter int ENC_DEPTH = 64,
    parameter int POR_CYCLES = `POR_CLOCKS,
    // Identification values, arbitrary
    parameter logic [7:0] SIG_MAKER = 8'h5a,
    parameter logic [7:0] SIG_MODEL = 8'h3c,
    parameter logic [7:0] SIG_EXTENSION = 8'h11
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Programming address, ports 1 and 2
    input wire logic [`ADDR_LO_BITS-1:0] port1_addr,
    input wire logic [`ADDR_HI_BITS-1:0] port2_addr,
    // Programming data, port 0
    input wire logic [7:0] port0_in,
    output logic [7:0] port0_out,
    output logic port0_oe,
    // Programming controls
    input wire logic [2:0] op_select,
    input wire logic program_strobe_n,
    input wire logic vpp_high,
    input wire logic program_strobe_enable_n,
    // Reset strap and oscillator detector
    input wire logic external_access_select_n,
    input wire logic oscillator_input_valid,
    // Core side
    input wire logic code_table_read,
    input wire logic fetch_external,
    input wire logic table_addr_internal,
    output logic code_table_read_block,
    output logic external_access_effective_n,
    output logic watchdog_por_enable,
    output logic core_reset_n
);

    localparam int MEM_W = $clog2(MEM_DEPTH);
    localparam int ENC_W = $clog2(ENC_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser

    logic rst_meta;
    logic rst_sync_n;

    // Release takes two edges so no flop sees a runt release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        eprom_port_pkg::program_strobe_pins_t meta;
        eprom_port_pkg::program_strobe_pins_t pins;
        logic ea_meta;
        logic ea_sync;
        logic [1:0] ea_wait;
        logic ea_taken;
        logic ea_latched;
        eprom_port_pkg::strobe_state_t fsm;
        logic [`PULSE_CNT_BITS-1:0] pulses;
        logic [`ADDR_BITS-1:0] last_addr;
        eprom_port_pkg::op_select_t last_op;
        logic [7:0] rd_data;
        logic rd_oe;
        logic [MEM_DEPTH-1:0][7:0] mem;
        logic [ENC_DEPTH-1:0][7:0] enc;
        logic [7:0] option;
        logic lock_n;
        logic wdt_por_en;
        logic ea_eff_n;
    } state_t;

    state_t st;
    state_t next_st;
    eprom_port_pkg::program_strobe_pins_t pin_group;

    assign pin_group.addr = {port2_addr, port1_addr}; // R01
    assign pin_group.data = port0_in;
    assign pin_group.op = eprom_port_pkg::op_select_t'(op_select);
    assign pin_group.program_strobe_n = program_strobe_n;
    assign pin_group.vpp_high = vpp_high;
    assign pin_group.program_strobe_enable_n = program_strobe_enable_n;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic is_program(input eprom_port_pkg::op_select_t op);
        is_program = (op == eprom_port_pkg::OP_PGM_ARRAY) || (op == eprom_port_pkg::OP_PGM_ENCRYPT) ||
                     (op == eprom_port_pkg::OP_PGM_LOCK) || (op == eprom_port_pkg::OP_PGM_OPTION);
    endfunction : is_program

    // Encryption array has no read operation at all
    function automatic logic is_read(input eprom_port_pkg::op_select_t op);
        is_read = (op == eprom_port_pkg::OP_VERIFY) || (op == eprom_port_pkg::OP_READ_OPTION) ||
                  (op == eprom_port_pkg::OP_READ_SIGNATURE); // R07 R15
    endfunction : is_read

    function automatic logic [`PULSE_CNT_BITS-1:0] pulses_needed(input eprom_port_pkg::op_select_t op);
        if (op == eprom_port_pkg::OP_PGM_ARRAY) begin
            pulses_needed = `PULSES_ARRAY; // R03
        end else begin
            pulses_needed = `PULSES_CONFIG; // R03
        end
    endfunction : pulses_needed

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [MEM_W-1:0] mem_idx;
        logic [ENC_W-1:0] enc_idx;
        logic [`PULSE_CNT_BITS-1:0] count_up;
        next_st = st;
        mem_idx = st.pins.addr[MEM_W-1:0];
        enc_idx = st.pins.addr[ENC_W-1:0];
        count_up = st.pulses + `PULSE_CNT_BITS'(1);

        // Two-flop synchronisers on every pin
        next_st.meta = pin_group;
        next_st.pins = st.meta;
        next_st.ea_meta = external_access_select_n;
        next_st.ea_sync = st.ea_meta;

        // Strap capture once the synchroniser holds a post-reset sample
        // Waiting avoids latching a sample taken while reset was still held
        if (!st.ea_taken) begin
            if (st.ea_wait == `EA_SETTLE) begin
                next_st.ea_taken = 1'b1;
                next_st.ea_latched = st.ea_sync; // R14
            end else begin
                next_st.ea_wait = st.ea_wait + 2'h1;
            end
        end

        // Pulse counting on each strobe rising edge
        case (st.fsm)
            eprom_port_pkg::ST_IDLE: begin
                if (!st.pins.program_strobe_n && st.pins.vpp_high && !st.pins.program_strobe_enable_n &&
                    is_program(st.pins.op)) begin // R02
                    next_st.fsm = eprom_port_pkg::ST_LOW;
                end
            end
            eprom_port_pkg::ST_LOW: begin
                if (st.pins.program_strobe_n) begin
                    next_st.pulses = count_up;
                    next_st.fsm = eprom_port_pkg::ST_IDLE;
                    if (count_up == pulses_needed(st.pins.op)) begin
                        next_st.fsm = eprom_port_pkg::ST_COUNTED;
                        // EPROM cells only go from one to zero
                        case (st.pins.op)
                            eprom_port_pkg::OP_PGM_ARRAY: begin
                                next_st.mem[mem_idx] = st.mem[mem_idx] & st.pins.data;
                            end
                            eprom_port_pkg::OP_PGM_ENCRYPT: begin
                                next_st.enc[enc_idx] = st.enc[enc_idx] & st.pins.data;
                            end
                            eprom_port_pkg::OP_PGM_LOCK: begin
                                next_st.lock_n = 1'b0;
                            end
                            eprom_port_pkg::OP_PGM_OPTION: begin
                                next_st.option = st.option & st.pins.data; // R11
                            end
                            default: begin
                                next_st.lock_n = st.lock_n;
                            end
                        endcase
                    end
                end
            end
            eprom_port_pkg::ST_COUNTED: begin
                // Extra strobes after the commit are ignored
                next_st.fsm = eprom_port_pkg::ST_COUNTED;
            end
            default: begin
                next_st.fsm = eprom_port_pkg::ST_IDLE;
            end
        endcase

        // A new address or operation starts a fresh byte
        // Trade-off: a pin glitch restarts the byte, never leaves a half count
        if (st.pins.addr != st.last_addr || st.pins.op != st.last_op || st.pins.program_strobe_enable_n) begin // R17
            next_st.pulses = '0;
            next_st.fsm = eprom_port_pkg::ST_IDLE;
        end
        next_st.last_addr = st.pins.addr;
        next_st.last_op = st.pins.op;

        // Status outputs from flops, so the core never sees a decode glitch
        next_st.wdt_por_en = ~st.option[`OPT_WDT_POR_BIT]; // R09
        // Unlocked follows the strap; locked shows the value taken after reset
        next_st.ea_eff_n = st.lock_n ? st.ea_sync : st.ea_latched; // R14

        // Read path
        next_st.rd_oe = !st.pins.program_strobe_enable_n && is_read(st.pins.op);
        case (st.pins.op)
            eprom_port_pkg::OP_VERIFY: begin
                // Always combined; all-ones encryption bytes pass data unchanged
                next_st.rd_data = ~(st.mem[mem_idx] ^ st.enc[enc_idx]); // R05 R06 R08
            end
            eprom_port_pkg::OP_READ_OPTION: begin
                next_st.rd_data = st.option;
            end
            eprom_port_pkg::OP_READ_SIGNATURE: begin
                if (st.pins.addr == `SIG_ADDR_MAKER) begin // R12
                    next_st.rd_data = SIG_MAKER;
                end else if (st.pins.addr == `SIG_ADDR_MODEL) begin
                    next_st.rd_data = SIG_MODEL;
                end else if (st.pins.addr == `SIG_ADDR_EXTENSION) begin
                    next_st.rd_data = SIG_EXTENSION;
                end else begin
                    next_st.rd_data = `ERASED_BYTE;
                end
            end
            default: begin
                next_st.rd_data = `ERASED_BYTE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    // Arrays are flip-flops set to the erased state by reset; a real part keeps
    // them across resets, so tests must program after the last reset.

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= '1;
            st.meta.vpp_high <= 1'b0;
            st.pins.vpp_high <= 1'b0;
            st.ea_wait <= 2'h0;
            st.ea_taken <= 1'b0;
            st.fsm <= eprom_port_pkg::ST_IDLE;
            st.pulses <= '0;
            st.rd_oe <= 1'b0;
            st.wdt_por_en <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on reset delay

    logic por_done;

    power_on_reset_counter #(
        .POR_CYCLES(POR_CYCLES)
    ) u_por (
        .clk(clk),
        .rst_n(rst_sync_n),
        .oscillator_input_valid(oscillator_input_valid),
        .por_done(por_done)
    );

    // Short delays are for simulation only; the default is the full count
    // Core is held until the delay ends, so options are valid before execution
    assign core_reset_n = por_done; // R16 R11

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign port0_out = st.rd_data;
    assign port0_oe = st.rd_oe;
    assign watchdog_por_enable = st.wdt_por_en; // R09
    // Lock reaches the outside only through these two effects
    assign code_table_read_block = ~st.lock_n & code_table_read & fetch_external & table_addr_internal; // R13 R15
    assign external_access_effective_n = st.ea_eff_n; // R14

endmodule : eprom_program_verify_port
`default_nettype wire

// *** eprom_port_checker.sv ***
// Assertions on the EPROM program/verify port, bound to its top module.
// Assumes one clock domain and the raw active-low reset of the top.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_port_defs.svh"

module eprom_port_checker #(
    parameter int POR_CYCLES = `POR_CLOCKS,
    parameter logic [7:0] SIG_MAKER = 8'h5a,
    parameter logic [7:0] SIG_MODEL = 8'h3c,
    parameter logic [7:0] SIG_EXTENSION = 8'h11
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Programming pins
    input wire logic [`ADDR_LO_BITS-1:0] port1_addr,
    input wire logic [`ADDR_HI_BITS-1:0] port2_addr,
    input wire logic [2:0] op_select,
    input wire logic program_strobe_enable_n,
    input wire logic [7:0] port0_out,
    input wire logic port0_oe,
    // Core side, strap and reset release
    input wire logic oscillator_input_valid,
    input wire logic code_table_read,
    input wire logic fetch_external,
    input wire logic table_addr_internal,
    input wire logic code_table_read_block,
    input wire logic external_access_effective_n,
    input wire logic watchdog_por_enable,
    input wire logic core_reset_n
);
    int vcnt;
    logic lock_seen;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // Counts from the raw release, so it runs ahead of the device
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vcnt <= 0;
            lock_seen <= 1'b0;
        end else begin
            if (oscillator_input_valid && vcnt < POR_CYCLES + 100) begin
                vcnt <= vcnt + 1;
            end
            if (code_table_read_block) begin
                lock_seen <= 1'b1;
            end
        end
    end
    sequence s_core_hit;
        code_table_read && fetch_external && table_addr_internal;
    endsequence
    // Pins held long enough for the three-cycle read path
    sequence s_read(logic [2:0] op, logic [13:0] adr);
        (!program_strobe_enable_n && op_select == op && {port2_addr, port1_addr} == adr)[*8];
    endsequence
    ////////////////////////////////////////////////////////////////
    a_block_cause: assert property (code_table_read_block |-> s_core_hit)
        else $error("block without internal external fetch");
    a_block_hold: assert property (code_table_read_block ##1 s_core_hit |-> code_table_read_block)
        else $error("lock effect dropped");
    a_strap_held: assert property (lock_seen && $past(lock_seen) |-> $stable(external_access_effective_n))
        else $error("latched strap changed under lock");
    a_por_hold: assert property (core_reset_n |-> vcnt >= POR_CYCLES)
        else $error("core reset released early");
    a_por_release: assert property (vcnt >= POR_CYCLES + 12 |-> core_reset_n)
        else $error("core reset released late");
    a_sig_maker: assert property (s_read(3'h6, 14'h0030) |-> port0_oe && port0_out == SIG_MAKER)
        else $error("maker byte wrong");
    a_sig_model: assert property (s_read(3'h6, 14'h0031) |-> port0_oe && port0_out == SIG_MODEL)
        else $error("model byte wrong");
    a_sig_ext: assert property (s_read(3'h6, 14'h0060) |-> port0_oe && port0_out == SIG_EXTENSION)
        else $error("extension byte wrong");
    a_opt_wdt: assert property (s_read(3'h5, 14'h0000) |-> port0_oe && port0_out[3] == !watchdog_por_enable)
        else $error("watchdog default disagrees with option");
    a_enc_hidden: assert property ((!program_strobe_enable_n && op_select == 3'h2)[*8] |-> !port0_oe || port0_out == 8'hff)
        else $error("encryption byte visible");
endmodule : eprom_port_checker

bind eprom_program_verify_port eprom_port_checker #(.POR_CYCLES(POR_CYCLES), .SIG_MAKER(SIG_MAKER),
    .SIG_MODEL(SIG_MODEL), .SIG_EXTENSION(SIG_EXTENSION)) u_checker (.clk, .rst_n, .port1_addr,
    .port2_addr, .op_select, .program_strobe_enable_n, .port0_out, .port0_oe, .oscillator_input_valid,
    .code_table_read, .fetch_external, .table_addr_internal, .code_table_read_block,
    .external_access_effective_n, .watchdog_por_enable, .core_reset_n);
`default_nettype wire

// *** eprom_programmer_model.sv ***
// Device programmer fixture: drives the programming pins, samples read-back.
// Assumes the device clock; pins change 1 ns after its rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_port_defs.svh"

module eprom_programmer_model (
    // Clock
    input wire logic clk,
    // Read-back
    input wire logic [7:0] port0_out,
    input wire logic port0_oe,
    // Programming pins
    output logic [`ADDR_LO_BITS-1:0] port1_addr,
    output logic [`ADDR_HI_BITS-1:0] port2_addr,
    output logic [7:0] port0_in,
    output logic [2:0] op_select,
    output logic program_strobe_n,
    output logic vpp_high,
    output logic program_strobe_enable_n,
    // Sampled read, drive enable above data
    output logic rd_valid,
    output logic [8:0] rd_data
);
    initial begin
        {port2_addr, port1_addr} = 14'h0000;
        port0_in = 8'h00;
        op_select = 3'h7;
        program_strobe_n = 1'b1;
        vpp_high = 1'b0;
        program_strobe_enable_n = 1'b1;
        rd_valid = 1'b0;
        rd_data = 9'h000;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // An address, operation or enable change mid-burst would void the pulse count
    task automatic pgm(input logic [2:0] op, input logic [13:0] a, input logic [7:0] d, input int n);
        step(1);
        {port2_addr, port1_addr} = a;
        step(1);
        port0_in = d;
        step(1);
        op_select = op;
        program_strobe_enable_n = 1'b0;
        step(1);
        vpp_high = 1'b1;
        step(4);
        repeat (n) begin
            program_strobe_n = 1'b0;
            step(4);
            program_strobe_n = 1'b1;
            step(4);
        end
        step(4);
        vpp_high = 1'b0;
        step(1);
        op_select = 3'h7;
        program_strobe_enable_n = 1'b1;
        // Released data lines must not keep the last value
        port0_in = ~d;
    endtask : pgm
    task automatic rd(input logic [2:0] op, input logic [13:0] a);
        step(1);
        {port2_addr, port1_addr} = a;
        op_select = op;
        program_strobe_enable_n = 1'b0;
        step(8);
        rd_data = {port0_oe, port0_out};
        rd_valid = 1'b1;
        step(1);
        rd_valid = 1'b0;
        program_strobe_enable_n = 1'b1;
        op_select = 3'h7;
    endtask : rd
endmodule : eprom_programmer_model
`default_nettype wire

// *** tb_top.sv ***
// Bench for the EPROM port: fixture drives reads and writes, a monitor checks.
// Assumes defs, package, design, checker and fixture are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_port_defs.svh"

module tb_top;
    localparam logic [13:0] SIG_ADR[3] = '{14'h0030, 14'h0031, 14'h0060};
    // Identification values, arbitrary
    localparam logic [7:0] SIG_VAL[3] = '{8'h5a, 8'h3c, 8'h11};
    logic clk, rst_n, external_access_select_n, oscillator_input_valid;
    logic code_table_read, fetch_external, table_addr_internal;
    logic [`ADDR_LO_BITS-1:0] port1_addr;
    logic [`ADDR_HI_BITS-1:0] port2_addr;
    logic [7:0] port0_in, port0_out, d, e;
    logic [2:0] op_select;
    logic program_strobe_n, vpp_high, program_strobe_enable_n, port0_oe, rd_valid;
    logic code_table_read_block, external_access_effective_n, watchdog_por_enable, core_reset_n;
    logic [8:0] rd_data;
    logic [13:0] a;
    logic [8:0] exp_q[$];
    int num_errors = 0;
    int total_checks = 0;
    int half_period = 25;
    eprom_program_verify_port #(.MEM_DEPTH(256), .POR_CYCLES(16), .SIG_MAKER(SIG_VAL[0]),
        .SIG_MODEL(SIG_VAL[1]), .SIG_EXTENSION(SIG_VAL[2])) DUT (.clk, .rst_n, .port1_addr,
        .port2_addr, .port0_in, .port0_out, .port0_oe, .op_select, .program_strobe_n, .vpp_high,
        .program_strobe_enable_n, .external_access_select_n, .oscillator_input_valid, .code_table_read,
        .fetch_external, .table_addr_internal, .code_table_read_block, .external_access_effective_n,
        .watchdog_por_enable, .core_reset_n);
    eprom_programmer_model fixture (.clk, .port0_out, .port0_oe, .port1_addr, .port2_addr, .port0_in,
        .op_select, .program_strobe_n, .vpp_high, .program_strobe_enable_n, .rd_valid, .rd_data);
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic chk1(input logic got, input logic exp);
        check({8'h00, got}, {8'h00, exp});
    endtask : chk1
    task automatic rdx(input logic [2:0] op, input logic [13:0] adr, input logic [7:0] v);
        exp_q.push_back({1'b1, v});
        fixture.rd(op, adr);
    endtask : rdx
    task automatic wait_por;
        for (int i = 0; i < 200 && core_reset_n !== 1'b1; i++) @(posedge clk);
        #1;
        if (core_reset_n !== 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_por
    always #(half_period) clk = ~clk;
    // A read with nothing expected must still count against the run
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() > 0) check(rd_data, exp_q.pop_front());
            else check(rd_data, 9'hxxx);
        end
    end
    initial begin
        #5000000;
        num_errors++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        external_access_select_n = 1'b0;
        oscillator_input_valid = 1'b0;
        {code_table_read, fetch_external, table_addr_internal} = 3'h0;
        void'($urandom(95496));
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        oscillator_input_valid = 1'b1;
        wait_por();
        for (int i = 0; i < 3; i++) rdx(3'h6, SIG_ADR[i], SIG_VAL[i]);
        rdx(3'h6, 14'h0032, 8'hff);
        rdx(3'h5, 14'h0000, 8'hff);
        chk1(watchdog_por_enable, 1'b0);
        a = 14'($urandom) & 14'h00ff;
        d = 8'($urandom);
        e = 8'($urandom) & 8'h7f;
        half_period = 100;
        fixture.pgm(3'h1, a, d, 5);
        rdx(3'h0, a, d);
        fixture.pgm(3'h1, a ^ 14'h0001, 8'h00, 4);
        rdx(3'h0, a ^ 14'h0001, 8'hff);
        fixture.pgm(3'h2, a, e, 25);
        rdx(3'h0, a, ~(d ^ e));
        fixture.pgm(3'h4, 14'h0000, 8'hf7, 25);
        rdx(3'h5, 14'h0000, 8'hf7);
        chk1(watchdog_por_enable, 1'b1);
        external_access_select_n = 1'b1;
        {code_table_read, fetch_external, table_addr_internal} = 3'h7;
        fixture.step(6);
        chk1(external_access_effective_n, 1'b1);
        chk1(code_table_read_block, 1'b0);
        external_access_select_n = 1'b0;
        fixture.pgm(3'h3, 14'h0000, 8'h00, 25);
        half_period = 25;
        fixture.step(2);
        chk1(code_table_read_block, 1'b1);
        external_access_select_n = 1'b1;
        fetch_external = 1'b0;
        fixture.step(6);
        chk1(external_access_effective_n, 1'b0);
        chk1(code_table_read_block, 1'b0);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
